// [logic/pxe_defs.vh]
`ifndef PXE_DEFS_VH
`define PXE_DEFS_VH

// ****************************************
// APB register offsets (byte addresses)
// ****************************************
`define PXE_REG_CTRL 8'h00
`define PXE_REG_STATUS 8'h04
`define PXE_REG_PORTS 8'h08
`define PXE_REG_ADDR 8'h0C

// ****************************************
// Control fields and reset value
// ****************************************
`define PXE_CTRL_SLAVE_EN 0
`define PXE_CTRL_DETECT_EN 1
`define PXE_CTRL_RESET 2'h3

// ****************************************
// Address-select levels, low-select coding
// ****************************************
`define PXE_LVL_LOW 2'h0
`define PXE_LVL_HIGH 2'h1
`define PXE_LVL_SCL 2'h2
`define PXE_LVL_SDA 2'h3
`define PXE_LVL_HI_FLIP 2'h2

// ****************************************
// Slave address groups
// ****************************************
`define PXE_GRP_IO 3'h6
`define PXE_GRP_OUT 3'h5

// ****************************************
// Bit counter and reset values
// ****************************************
`define PXE_BITS_PER_BYTE 4'h8
`define PXE_OUT_RESET 12'h000
`define PXE_PORT_RESET 4'h0

`endif

// [logic/pxe_expander.v]
`include "pxe_defs.vh"

module pxe_expander (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire por_ok,
	input wire hw_rst_n,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire addr_sel_lo,
	input wire addr_sel_hi,
	input wire [3:0] io_port_in,
	output reg [3:0] io_port_out,
	output reg [3:0] io_port_oe,
	output reg [3:0] pullup_en,
	output reg [11:0] push_out,
	output reg int_n,
	output reg standby
);

	// ****************************************
	// States
	// ****************************************
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_ACK_A = 7'h04;
	localparam [6:0] ST_WRITE = 7'h08;
	localparam [6:0] ST_ACK_W = 7'h10;
	localparam [6:0] ST_READ = 7'h20;
	localparam [6:0] ST_ACK_R = 7'h40;

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Order: io[3:0], sel_hi, sel_lo, sda, scl, hw_rst_n, por_ok
	wire [9:0] raw_in;
	reg [9:0] s1_q;
	reg [9:0] s2_q;
	assign raw_in = {io_port_in, addr_sel_hi, addr_sel_lo, sda_in, scl_in, hw_rst_n, por_ok};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle bus and reset levels, so no false edge follows reset
			s1_q <= 10'h00E;
			s2_q <= 10'h00E;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
		end
	end

	wire por_s = s2_q[0];
	wire hwr_n_s = s2_q[1];
	wire scl_s = s2_q[2];
	wire sda_s = s2_q[3];
	wire [1:0] sel_s = s2_q[5:4];
	wire [3:0] io_s = s2_q[9:6];
	// All but the APB slave and the latched select levels held in reset without supply indication
	wire run = por_s;

	// ****************************************
	// Bus conditions
	// ****************************************
	reg scl_p_q;
	reg sda_p_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ****************************************
	// Four-level select decode
	// ****************************************
	// Trackers run from START to STOP, so any transmission re-decodes
	reg busy_q;
	reg [1:0] seen0_q;
	reg [1:0] seen1_q;
	reg [1:0] ne_sda_q;
	reg [1:0] ne_scl_q;
	reg [1:0] lvl_live [0:1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sel
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					seen0_q[gi] <= 1'b0;
					seen1_q[gi] <= 1'b0;
					ne_sda_q[gi] <= 1'b0;
					ne_scl_q[gi] <= 1'b0;
				end else if (!run || start_c) begin
					seen0_q[gi] <= 1'b0;
					seen1_q[gi] <= 1'b0;
					ne_sda_q[gi] <= 1'b0;
					ne_scl_q[gi] <= 1'b0;
				end else if (busy_q) begin
					seen0_q[gi] <= seen0_q[gi] | ~sel_s[gi];
					seen1_q[gi] <= seen1_q[gi] | sel_s[gi];
					ne_sda_q[gi] <= ne_sda_q[gi] | (sel_s[gi] ^ sda_s);
					ne_scl_q[gi] <= ne_scl_q[gi] | (sel_s[gi] ^ scl_s);
				end
			end

			always @* begin
				if (!seen0_q[gi]) lvl_live[gi] = `PXE_LVL_HIGH;
				else if (!seen1_q[gi]) lvl_live[gi] = `PXE_LVL_LOW;
				else if (!ne_scl_q[gi]) lvl_live[gi] = `PXE_LVL_SCL;
				else if (!ne_sda_q[gi]) lvl_live[gi] = `PXE_LVL_SDA;
				else lvl_live[gi] = `PXE_LVL_HIGH;
			end
		end
	endgenerate

	// Slave addresses from the live decode
	wire [1:0] hi_code = lvl_live[1] ^ `PXE_LVL_HI_FLIP;
	wire [6:0] addr_io = {`PXE_GRP_IO, hi_code, lvl_live[0]};
	wire [6:0] addr_out = {`PXE_GRP_OUT, hi_code, lvl_live[0]};

	// ****************************************
	// Registers and state
	// ****************************************
	reg [1:0] ctrl_q;
	reg init_q;
	reg decoded_q;
	reg [1:0] lvl_lo_q;
	reg [1:0] lvl_hi_q;
	reg [6:0] st_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg [7:0] tx_q;
	reg rw_q;
	reg grp_out_q;
	reg rd_idx_q;
	reg nack_q;
	reg [3:0] port_q;
	reg [3:0] io_prev_q;
	reg [3:0] flag_q;
	reg access_q;

	wire lo_on = (lvl_lo_q != `PXE_LVL_LOW);
	wire hi_on = (lvl_hi_q != `PXE_LVL_LOW);
	wire [3:0] change = (io_s ^ io_prev_q) & {4{ctrl_q[`PXE_CTRL_DETECT_EN] & init_q}};
	wire [7:0] byte_io = {push_out[3:2], io_s, push_out[1:0]};
	wire [7:0] byte_flag = {2'b00, flag_q, 2'b00};

	// ****************************************
	// Power-up straps and decoded levels
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_q <= 1'b0;
			decoded_q <= 1'b0;
			lvl_lo_q <= `PXE_LVL_HIGH;
			lvl_hi_q <= `PXE_LVL_HIGH;
		end else if (!run) begin
			init_q <= 1'b0;
			decoded_q <= 1'b0;
		end else if (!init_q) begin
			init_q <= 1'b1;
			// Data and clock lines float high here, so two levels suffice
			lvl_lo_q <= sel_s[0] ? `PXE_LVL_HIGH : `PXE_LVL_LOW;
			lvl_hi_q <= sel_s[1] ? `PXE_LVL_HIGH : `PXE_LVL_LOW;
		end else if (st_q == ST_ADDR && scl_fall && cnt_q == `PXE_BITS_PER_BYTE) begin
			decoded_q <= 1'b1;
			lvl_lo_q <= lvl_live[0];
			lvl_hi_q <= lvl_live[1];
		end
	end

	// ****************************************
	// Pullups and standby
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_en <= 4'h0;
			standby <= 1'b1;
		end else begin
			pullup_en <= {4{run}} & {hi_on, hi_on, lo_on, lo_on};
			standby <= ~busy_q;
		end
	end

	// ****************************************
	// Serial slave
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			grp_out_q <= 1'b0;
			rd_idx_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			access_q <= 1'b0;
			port_q <= `PXE_PORT_RESET;
			push_out <= `PXE_OUT_RESET;
		end else if (!run) begin
			st_q <= ST_IDLE;
			busy_q <= 1'b0;
			sda_oe <= 1'b0;
			access_q <= 1'b0;
			port_q <= `PXE_PORT_RESET;
			push_out <= `PXE_OUT_RESET;
		end else if (!init_q) begin
			// Defaults follow the two-level strap view, taken this same edge
			port_q <= {sel_s[1], sel_s[1], sel_s[0], sel_s[0]};
			push_out <= {{4{sel_s[1]}}, {4{sel_s[0]}}, sel_s[1], sel_s[1], sel_s[0], sel_s[0]};
		end else if (!hwr_n_s) begin
			st_q <= ST_IDLE;
			busy_q <= 1'b0;
			sda_oe <= 1'b0;
			access_q <= 1'b0;
		end else begin
			access_q <= 1'b0;
			if (start_c) begin
				st_q <= ST_ADDR;
				busy_q <= 1'b1;
				cnt_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st_q <= ST_IDLE;
				busy_q <= 1'b0;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (st_q == ST_ADDR || st_q == ST_WRITE || st_q == ST_READ) begin
					sh_q <= {sh_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end
				if (st_q == ST_ACK_R) nack_q <= sda_s;
			end else if (scl_fall) begin
				case (st_q)
					ST_ADDR: begin
						if (cnt_q == `PXE_BITS_PER_BYTE) begin
							if (ctrl_q[`PXE_CTRL_SLAVE_EN] &&
								(sh_q[7:1] == addr_io || sh_q[7:1] == addr_out)) begin
								sda_oe <= 1'b1;
								access_q <= 1'b1;
								rw_q <= sh_q[0];
								grp_out_q <= (sh_q[7:1] == addr_out);
								st_q <= ST_ACK_A;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					ST_ACK_A: begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							tx_q <= grp_out_q ? push_out[11:4] : byte_io;
							sda_oe <= ~(grp_out_q ? push_out[11] : byte_io[7]);
							rd_idx_q <= 1'b1;
							st_q <= ST_READ;
						end else begin
							sda_oe <= 1'b0;
							st_q <= ST_WRITE;
						end
					end
					ST_WRITE: begin
						if (cnt_q == `PXE_BITS_PER_BYTE) begin
							if (grp_out_q) begin
								push_out[11:4] <= sh_q;
							end else begin
								push_out[3:2] <= sh_q[7:6];
								port_q <= sh_q[5:2];
								push_out[1:0] <= sh_q[1:0];
							end
							sda_oe <= 1'b1;
							st_q <= ST_ACK_W;
						end
					end
					ST_ACK_W: begin
						sda_oe <= 1'b0;
						cnt_q <= 4'h0;
						st_q <= ST_WRITE;
					end
					ST_READ: begin
						if (cnt_q == `PXE_BITS_PER_BYTE) begin
							sda_oe <= 1'b0;
							st_q <= ST_ACK_R;
						end else begin
							sda_oe <= ~tx_q[3'd7 - cnt_q[2:0]];
						end
					end
					ST_ACK_R: begin
						if (nack_q) begin
							sda_oe <= 1'b0;
							st_q <= ST_IDLE;
						end else begin
							cnt_q <= 4'h0;
							rd_idx_q <= ~rd_idx_q;
							if (grp_out_q) begin
								tx_q <= push_out[11:4];
								sda_oe <= ~push_out[11];
							end else if (rd_idx_q) begin
								tx_q <= byte_flag;
								sda_oe <= ~byte_flag[7];
							end else begin
								tx_q <= byte_io;
								sda_oe <= ~byte_io[7];
							end
							st_q <= ST_READ;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Open-drain ports
	// ****************************************
	// A port written high releases the pin so it can read as input
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_port_oe <= 4'h0;
			io_port_out <= 4'h0;
		end else begin
			io_port_oe <= ~port_q & {4{init_q}};
			io_port_out <= 4'h0;
		end
	end

	// ****************************************
	// Transition flags and interrupt
	// ****************************************
	// A change in the access cycle survives: set wins over clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_prev_q <= 4'h0;
			flag_q <= 4'h0;
			int_n <= 1'b1;
		end else if (!run || !init_q) begin
			io_prev_q <= io_s;
			flag_q <= 4'h0;
			int_n <= 1'b1;
		end else begin
			io_prev_q <= io_s;
			flag_q <= (flag_q & {4{~access_q}}) | change;
			// Hardware reset does not reach here on purpose
			if (|change) int_n <= 1'b0;
			else if (access_q) int_n <= 1'b1;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	wire setup = psel & ~penable;
	wire wr_go = psel & penable & pready & pwrite;
	reg [31:0] rd_d;
	reg err_d;

	always @* begin
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		case (paddr)
			`PXE_REG_CTRL: rd_d = {30'h0000_0000, ctrl_q};
			`PXE_REG_STATUS: rd_d = {24'h00_0000, busy_q, decoded_q, standby, ~int_n, flag_q};
			`PXE_REG_PORTS: rd_d = {12'h000, push_out, port_q, io_s};
			`PXE_REG_ADDR: rd_d = {8'h00, pullup_en, lvl_hi_q, lvl_lo_q, 1'b0, addr_out, 1'b0, addr_io};
			default: err_d = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PXE_CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= err_d;
			end
			if (wr_go && paddr == `PXE_REG_CTRL) ctrl_q <= pwdata[1:0];
		end
	end

endmodule // pxe_expander

// [sim/pxe_expander_asserts.sv]
module pxe_expander_asserts (
	input logic pclk,
	input logic presetn,
	input logic por_ok,
	input logic hw_rst_n,
	input logic scl_in,
	input logic sda_in,
	input logic sda_out,
	input logic sda_oe,
	input logic [3:0] io_port_in,
	input logic [3:0] io_port_out,
	input logic [3:0] pullup_en,
	input logic int_n,
	input logic standby
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Port-side checks
	// ****************************************
	chk_int_release: assert property ($rose(int_n) && por_ok |-> ##[0:2] sda_oe)
		else $error("interrupt released without an acknowledged access");
	chk_int_hold_rst: assert property (!hw_rst_n && !int_n && por_ok |=> !int_n)
		else $error("hardware reset touched the interrupt");
	chk_start_idle: assert property ($fell(standby) |-> scl_in && !sda_in)
		else $error("standby left without a start");
	chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data line driven while clock high");
	chk_por_clear: assert property ((!por_ok) [*4] |-> int_n && !sda_oe)
		else $error("supply low but not held in reset");
	chk_pullup_pairs: assert property (pullup_en[0] == pullup_en[1] && pullup_en[2] == pullup_en[3])
		else $error("pullups not switched in pairs");
	chk_drive_low: assert property (sda_out == 1'h0 && io_port_out == 4'h0)
		else $error("open-drain output driven high");
	// Either sync depth tolerated, a one-cycle pulse still shows a change
	chk_int_cause: assert property ($fell(int_n) |->
		$past(io_port_in, 2) != $past(io_port_in, 3) || $past(io_port_in, 3) != $past(io_port_in, 4))
		else $error("interrupt without an input change");
endmodule // pxe_expander_asserts

bind pxe_expander pxe_expander_asserts i_pxe_expander_asserts (.pclk, .presetn, .por_ok, .hw_rst_n, .scl_in,
	.sda_in, .sda_out, .sda_oe, .io_port_in, .io_port_out, .pullup_en, .int_n, .standby);

// [sim/pxe_i2c_master.sv]
module pxe_i2c_master (
	input logic pclk,
	input logic sda_line,
	output logic scl,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quarter bit (clock holds each level for 2*HALF), far above the slave's sync delay
	localparam int HALF = 20;
	initial begin
		scl = 1'h1;
		sda_pull = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic start();
		tick(HALF);
		sda_pull <= 1'h1;
		tick(HALF);
		scl <= 1'h0;
	endtask
	task automatic stop();
		tick(HALF);
		sda_pull <= 1'h1;
		tick(HALF);
		scl <= 1'h1;
		tick(HALF);
		sda_pull <= 1'h0;
	endtask
	// Line is released in the ninth slot, so the pull-up shows a missing ack
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 0; i < 9; i++) begin
			tick(HALF);
			sda_pull <= (i < 8) ? !b[7 - i] : 1'h0;
			tick(HALF);
			scl <= 1'h1;
			tick(2 * HALF);
			ack = !sda_line;
			scl <= 1'h0;
		end
	endtask
	// Ninth slot acknowledges, or leaves the line released on the last byte
	task automatic recv(input logic last, output logic [7:0] b);
		for (int i = 0; i < 9; i++) begin
			tick(HALF);
			sda_pull <= (i == 8) ? !last : 1'h0;
			tick(HALF);
			scl <= 1'h1;
			tick(2 * HALF);
			if (i < 8) b[7 - i] = sda_line;
			scl <= 1'h0;
		end
	endtask
endmodule // pxe_i2c_master

// [sim/pxe_expander_test.sv]
`include "pxe_defs.vh"
module pxe_expander_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, por_ok, hw_rst_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, sda_out, sda_oe, int_n, standby, scl, sda_pull, ack, er;
	logic [3:0] io_in, io_port_out, io_port_oe, pullup_en;
	logic [11:0] push_out;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	wire sda_line = !(sda_pull || sda_oe);
	logic [7:0] b0, b1;
	logic lo_scl = 1'h0;
	// Low select either tied low or tied to the clock line
	wire sel_lo_pin = lo_scl && scl;
	// High select at supply keeps ports four, five high for input use
	pxe_expander i_pxe_expander (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .por_ok, .hw_rst_n, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .addr_sel_lo(sel_lo_pin),
		.addr_sel_hi(1'h1), .io_port_in(io_in), .io_port_out, .io_port_oe, .pullup_en, .push_out, .int_n,
		.standby);
	pxe_i2c_master i_pxe_i2c_master (.pclk, .sda_line, .scl, .sda_pull);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic final_report();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic i2c(input logic [7:0] a, input logic [7:0] d);
		i_pxe_i2c_master.start();
		i_pxe_i2c_master.send(a, ack);
		if (ack === 1'h1) i_pxe_i2c_master.send(d, er);
		i_pxe_i2c_master.stop();
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		por_ok = 1'h1;
		hw_rst_n = 1'h1;
		io_in = 4'hC;
		wt(4);
		presetn <= 1'h1;
		wt(10);
		chk(32'(pullup_en), 32'h0000_000C);
		chk(32'(io_port_oe), 32'h0000_0003);
		chk(32'(push_out), 32'h0000_0F0C);
		chk(32'(int_n), 32'h0000_0001);
		apb(1'h0, 8'h10, 32'h0000_0000);
		chk({rd[30:0], er}, 32'h0000_0001);
		io_in <= 4'h8;
		wt(1);
		io_in <= 4'hC;
		wt(8);
		chk(32'(int_n), 32'h0000_0000);
		apb(1'h0, `PXE_REG_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_001F, 32'h0000_0014);
		i_pxe_i2c_master.start();
		wt(10);
		chk(32'(standby), 32'h0000_0000);
		hw_rst_n <= 1'h0;
		wt(4);
		hw_rst_n <= 1'h1;
		wt(6);
		chk(32'(standby), 32'h0000_0001);
		chk(32'(int_n), 32'h0000_0000);
		i_pxe_i2c_master.stop();
		i2c(8'hD8, 8'hFF);
		chk({ack, er, int_n}, 32'h0000_0007);
		chk(32'(io_port_oe), 32'h0000_0000);
		chk(32'(push_out), 32'h0000_0F0F);
		apb(1'h0, `PXE_REG_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_000F, 32'h0000_0000);
		i_pxe_i2c_master.start();
		i_pxe_i2c_master.send(8'hD9, ack);
		i_pxe_i2c_master.recv(1'h0, b0);
		i_pxe_i2c_master.recv(1'h1, b1);
		i_pxe_i2c_master.stop();
		chk({ack, b0, b1}, 32'h0001_F300);
		i2c(8'hB8, 8'hA5);
		chk(32'(push_out), 32'h0000_0A5F);
		i2c(8'hDA, 8'h00);
		chk(32'(ack), 32'h0000_0000);
		apb(1'h0, `PXE_REG_ADDR, 32'h0000_0000);
		chk(rd & 32'h00FF_7F7F, 32'h00C4_5C6C);
		apb(1'h1, `PXE_REG_CTRL, 32'h0000_0000);
		i2c(8'hD8, 8'h00);
		chk(32'(ack), 32'h0000_0000);
		por_ok <= 1'h0;
		wt(8);
		por_ok <= 1'h1;
		wt(10);
		chk({push_out, io_port_oe, 3'h0, int_n}, 32'h000F_0C31);
		lo_scl <= 1'h1;
		por_ok <= 1'h0;
		wt(8);
		por_ok <= 1'h1;
		wt(10);
		chk({push_out, pullup_en}, 32'h0000_FFFF);
		apb(1'h1, `PXE_REG_CTRL, 32'h0000_0003);
		i2c(8'hDC, 8'h3C);
		chk({ack, er}, 32'h0000_0003);
		chk(32'(push_out), 32'h0000_0FF0);
		apb(1'h0, `PXE_REG_ADDR, 32'h0000_0000);
		chk(rd & 32'h00FF_7F7F, 32'h00F6_5E6E);
		final_report();
	end
endmodule // pxe_expander_test
